// [rtl/wwdt_defs.svh]
/*
 Constants for the windowed watchdog: register offsets, field positions,
 feed keys, reset values and tick source counts.
 Assumes a 32-bit classic Wishbone slave with word addresses in byte units.
*/
`ifndef WWDT_DEFS_SVH
`define WWDT_DEFS_SVH

`define WWDT_CTRL_OFS        4'h0
`define WWDT_FEED_OFS        4'h4
`define WWDT_CLKSEL_OFS      4'h8
`define WWDT_COUNT_OFS       4'hC

`define WWDT_BIT_RST_LATE    31
`define WWDT_BIT_RST_EARLY   30
`define WWDT_BIT_WIN_EN      29
`define WWDT_BIT_CLKRDY      28
`define WWDT_BIT_CLKRDY_IE   27
`define WWDT_RST_EARLY_HI    23
`define WWDT_RST_EARLY_LO    20
`define WWDT_INT_EARLY_HI    19
`define WWDT_INT_EARLY_LO    16
`define WWDT_BIT_INT_EARLY   12
`define WWDT_BIT_RST_EN      11
`define WWDT_BIT_INT_EN      10
`define WWDT_BIT_INT_LATE    9
`define WWDT_BIT_EN          8
`define WWDT_RST_LATE_HI     7
`define WWDT_RST_LATE_LO     4
`define WWDT_INT_LATE_HI     3
`define WWDT_INT_LATE_LO     0

`define WWDT_KEY_FIRST       8'hA5
`define WWDT_KEY_SECOND      8'h5A
`define WWDT_COUNT_ZERO      32'h0000_0000
`define WWDT_EXP_BASE        5'h1F
`define WWDT_CTRL_WMASK      32'hE8FF_1EFF
`define WWDT_SRC_W           2
`define WWDT_SRC_MAIN_N      2'h2
`define WWDT_SRC_LP_N        2'h3

`endif

// [rtl/wwdt_pkg.sv]
/*
 Types shared by the windowed watchdog.
 Assumes wwdt_defs.svh is included where constants are needed.
*/
package wwdt_pkg;
	typedef enum logic [1:0] {
		WWDT_FEED_IDLE,
		WWDT_FEED_ARMED
	} wwdt_feed_e;

	typedef enum logic [1:0] {
		WWDT_CLK_OFF,
		WWDT_CLK_SWITCH,
		WWDT_CLK_ON
	} wwdt_clk_e;
endpackage : wwdt_pkg

// [rtl/wwdt_timer.sv]
/*
 Windowed watchdog timer core with a classic Wishbone register slave.
 Assumes tick sources arrive asynchronously as pins and are synchronised here;
 the system reset logic answers sys_rst_req_o and then pulses sys_rst_i.
*/
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "wwdt_defs.svh"

module wwdt_timer
	import wwdt_pkg::*;
#(
	parameter bit LOW_POWER = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [2:0]  tick_src_i,
	input  wire logic        sleep_i,
	input  wire logic        deep_power_i,
	output logic             irq_o,
	output logic             sys_rst_req_o,
	output logic             clk_ready_evt_o,
	output logic             wake_o
);

	////////////////////////////////////////////////////////////////////////////
	// Registers and wires

	logic        rst_late_reg;
	logic        rst_early_reg;
	logic        win_en_reg;
	logic        clkrdy_reg;
	logic        clkrdy_ie_reg;
	logic [3:0]  rst_early_val_reg;
	logic [3:0]  int_early_val_reg;
	logic        int_early_reg;
	logic        rst_en_reg;
	logic        int_en_reg;
	logic        int_late_reg;
	logic        en_reg;
	logic [3:0]  rst_late_val_reg;
	logic [3:0]  int_late_val_reg;
	logic [1:0]  clksel_reg;
	logic [31:0] watchdog_count_reg;
	logic [31:0] count_next;
	wwdt_feed_e  feed_reg;
	wwdt_clk_e   clk_state_reg;
	logic [2:0]  tick_meta_reg;
	logic [2:0]  tick_sync_reg;
	logic        tick_prev_reg;
	logic        tick_sel;
	logic        tick;
	logic        wr;
	logic        rd_sel;
	logic        feed_wr;
	logic        feed_done;
	logic        early_int_evt;
	logic        early_rst_evt;
	logic        late_int_evt;
	logic        late_rst_evt;
	logic        rst_evt;
	logic        ctrl_wr;
	logic [31:0] ctrl_wdata;
	logic [31:0] ctrl_rd;

	// Limit code n selects the count value two to the power (31 - n)
	function automatic logic [31:0] wwdt_limit(input logic [3:0] code);
		logic [4:0] sh;
		sh = `WWDT_EXP_BASE - {1'b0, code};
		wwdt_limit = 32'h0000_0001 << sh;
	endfunction : wwdt_limit

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave, one wait-free answer per request

	assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign rd_sel  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign feed_wr = wr & wb_sel_i[0] & (wb_adr_i == `WWDT_FEED_OFS);
	assign ctrl_wr = wr & (wb_adr_i == `WWDT_CTRL_OFS);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= rd_sel;
		end
	end

	assign ctrl_rd = {rst_late_reg, rst_early_reg, win_en_reg, clkrdy_reg, clkrdy_ie_reg,
		3'h0, rst_early_val_reg, int_early_val_reg, 3'h0, int_early_reg, rst_en_reg,
		int_en_reg, int_late_reg, en_reg, rst_late_val_reg, int_late_val_reg};

	// Unmapped addresses read as zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i && rd_sel) begin
			case (wb_adr_i)
				`WWDT_CTRL_OFS:   wb_dat_o <= ctrl_rd;
				`WWDT_CLKSEL_OFS: wb_dat_o <= {30'h0, clksel_reg};
				`WWDT_COUNT_OFS:  wb_dat_o <= watchdog_count_reg;
				default:          wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Byte-lane merge of a control write
	always_comb begin
		ctrl_wdata = ctrl_rd;
		for (int i = 0; i < 4; i++) begin
			if (wb_sel_i[i]) begin
				ctrl_wdata[i*8 +: 8] = wb_dat_i[i*8 +: 8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Feed detector

	always_ff @(posedge clk_i) begin
		if (rst_i || sys_rst_i) begin
			feed_reg <= WWDT_FEED_IDLE;
		end else if (ce_i && feed_wr) begin
			case (feed_reg)
				WWDT_FEED_IDLE: begin
					if (wb_dat_i[7:0] == `WWDT_KEY_FIRST) begin
						feed_reg <= WWDT_FEED_ARMED;
					end
				end
				// Any second write ends the attempt; a fresh first key re-arms
				WWDT_FEED_ARMED: begin
					if (wb_dat_i[7:0] == `WWDT_KEY_FIRST) begin
						feed_reg <= WWDT_FEED_ARMED;
					end else begin
						feed_reg <= WWDT_FEED_IDLE;
					end
				end
				default: feed_reg <= WWDT_FEED_IDLE;
			endcase
		end
	end

	assign feed_done = feed_wr & (feed_reg == WWDT_FEED_ARMED)
		& (wb_dat_i[7:0] == `WWDT_KEY_SECOND);

	////////////////////////////////////////////////////////////////////////////
	// Tick source synchronisers and edge detect

	for (genvar g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				tick_meta_reg[g] <= 1'b0;
				tick_sync_reg[g] <= 1'b0;
			end else if (ce_i) begin
				tick_meta_reg[g] <= tick_src_i[g];
				tick_sync_reg[g] <= tick_meta_reg[g];
			end
		end
	end

	// Main instance offers two sources, low-power three
	always_comb begin
		if (clksel_reg < (LOW_POWER ? `WWDT_SRC_LP_N : `WWDT_SRC_MAIN_N)) begin
			tick_sel = tick_sync_reg[clksel_reg];
		end else begin
			tick_sel = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_prev_reg <= 1'b0;
		end else if (ce_i) begin
			tick_prev_reg <= tick_sel;
		end
	end

	// Gated tick stands in for the stopped watchdog clock
	assign tick = tick_sel & ~tick_prev_reg & (clk_state_reg == WWDT_CLK_ON);

	////////////////////////////////////////////////////////////////////////////
	// Count and events

	always_comb begin
		count_next = watchdog_count_reg + 32'h0000_0001;
	end

	assign late_int_evt  = tick & (count_next == wwdt_limit(int_late_val_reg));
	assign late_rst_evt  = tick & (count_next == wwdt_limit(rst_late_val_reg));
	assign early_rst_evt = feed_done
		& (watchdog_count_reg < wwdt_limit(rst_early_val_reg));
	assign early_int_evt = feed_done & ~early_rst_evt
		& (watchdog_count_reg < wwdt_limit(int_early_val_reg));
	// Early reset acts only with the window on; late ones always
	assign rst_evt = rst_en_reg & (late_rst_evt | (early_rst_evt & win_en_reg));

	always_ff @(posedge clk_i) begin
		if (rst_i || sys_rst_i) begin
			watchdog_count_reg <= `WWDT_COUNT_ZERO;
		end else if (ce_i) begin
			if (feed_done) begin
				watchdog_count_reg <= `WWDT_COUNT_ZERO;
			end else if (tick) begin
				watchdog_count_reg <= count_next;
			end
		end
	end

	// Single-cycle request toward the system reset logic
	always_ff @(posedge clk_i) begin
		if (rst_i || sys_rst_i) begin
			sys_rst_req_o <= 1'b0;
		end else if (ce_i) begin
			sys_rst_req_o <= rst_evt & ~sys_rst_req_o;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register; enable and reset flags survive system reset

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_late_reg  <= 1'b0;
			rst_early_reg <= 1'b0;
			en_reg        <= 1'b0;
		end else if (ce_i) begin
			if (ctrl_wr) begin
				rst_late_reg  <= ctrl_wdata[`WWDT_BIT_RST_LATE];
				rst_early_reg <= ctrl_wdata[`WWDT_BIT_RST_EARLY];
				en_reg        <= ctrl_wdata[`WWDT_BIT_EN];
			end
			// Hardware set wins over a software clear
			if (late_rst_evt) begin
				rst_late_reg <= 1'b1;
			end
			if (early_rst_evt) begin
				rst_early_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || sys_rst_i) begin
			win_en_reg        <= 1'b0;
			clkrdy_ie_reg     <= 1'b0;
			rst_early_val_reg <= 4'h0;
			int_early_val_reg <= 4'h0;
			int_early_reg     <= 1'b0;
			rst_en_reg        <= 1'b0;
			int_en_reg        <= 1'b0;
			int_late_reg      <= 1'b0;
			rst_late_val_reg  <= 4'h0;
			int_late_val_reg  <= 4'h0;
			clksel_reg        <= 2'h0;
		end else if (ce_i) begin
			if (ctrl_wr) begin
				win_en_reg        <= ctrl_wdata[`WWDT_BIT_WIN_EN];
				clkrdy_ie_reg     <= ctrl_wdata[`WWDT_BIT_CLKRDY_IE];
				rst_early_val_reg <= ctrl_wdata[`WWDT_RST_EARLY_HI:`WWDT_RST_EARLY_LO];
				int_early_val_reg <= ctrl_wdata[`WWDT_INT_EARLY_HI:`WWDT_INT_EARLY_LO];
				int_early_reg     <= ctrl_wdata[`WWDT_BIT_INT_EARLY];
				rst_en_reg        <= ctrl_wdata[`WWDT_BIT_RST_EN];
				int_en_reg        <= ctrl_wdata[`WWDT_BIT_INT_EN];
				int_late_reg      <= ctrl_wdata[`WWDT_BIT_INT_LATE];
				rst_late_val_reg  <= ctrl_wdata[`WWDT_RST_LATE_HI:`WWDT_RST_LATE_LO];
				int_late_val_reg  <= ctrl_wdata[`WWDT_INT_LATE_HI:`WWDT_INT_LATE_LO];
			end
			if (wr && wb_sel_i[0] && wb_adr_i == `WWDT_CLKSEL_OFS) begin
				clksel_reg <= wb_dat_i[`WWDT_SRC_W-1:0];
			end
			if (early_int_evt) begin
				int_early_reg <= 1'b1;
			end
			if (late_int_evt) begin
				int_late_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock switch status; one tick-free cycle models the switch delay

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_state_reg <= WWDT_CLK_OFF;
			clkrdy_reg    <= 1'b0;
		end else if (ce_i) begin
			if (ctrl_wr && wb_sel_i[1] && (wb_dat_i[`WWDT_BIT_EN] != en_reg)) begin
				clk_state_reg <= WWDT_CLK_SWITCH;
				clkrdy_reg    <= 1'b0;
			end else begin
				case (clk_state_reg)
					WWDT_CLK_SWITCH: begin
						clk_state_reg <= en_reg ? WWDT_CLK_ON : WWDT_CLK_OFF;
						clkrdy_reg    <= 1'b1;
					end
					WWDT_CLK_ON:  clk_state_reg <= en_reg ? WWDT_CLK_ON : WWDT_CLK_SWITCH;
					WWDT_CLK_OFF: clk_state_reg <= en_reg ? WWDT_CLK_SWITCH : WWDT_CLK_OFF;
					default:      clk_state_reg <= WWDT_CLK_OFF;
				endcase
			end
		end
	end

	// Ready rising is a separate event output, never an event flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_ready_evt_o <= 1'b0;
		end else if (ce_i) begin
			clk_ready_evt_o <= clkrdy_ie_reg & (clk_state_reg == WWDT_CLK_SWITCH);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt and wake-up levels

	// Early interrupt drives the line only with the window on
	assign irq_o = int_en_reg & (int_late_reg | (int_early_reg & win_en_reg));

	// Deeper power states wake only the low-power instance
	assign wake_o = irq_o & (sleep_i | (deep_power_i & LOW_POWER));

endmodule : wwdt_timer

// [test/wwdt_rst_model.sv]
/*
 System reset partner: answers each reset request with a one-cycle reset pulse.
 Assumes requests arrive as single-cycle pulses on the block clock.
*/
`timescale 1ns/1ps
module wwdt_rst_model #(
	parameter int DELAY = 3
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_req_i,
	output logic      sys_rst_o,
	output int        n_req_o
);
	int wait_q = 0;
	initial sys_rst_o = 1'b0;
	initial n_req_o = 0;
	// Delay stands in for a slow reset controller
	always @(posedge clk_i) begin
		sys_rst_o <= (wait_q == 1);
		if (sys_rst_req_i === 1'b1) begin
			n_req_o <= n_req_o + 1;
			wait_q <= DELAY;
		end else if (wait_q > 0) begin
			wait_q <= wait_q - 1;
		end
	end
endmodule : wwdt_rst_model

// [test/wwdt_timer_checker.sv]
/*
 Port assertions for the watchdog core.
 Assumes a bind to wwdt_timer; rst_i is synchronous, active high.
*/
`timescale 1ns/1ps
module wwdt_timer_checker #(
	parameter bit LOW_POWER = 1'b0
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        sleep_i,
	input wire logic        deep_power_i,
	input wire logic        irq_o,
	input wire logic        sys_rst_req_o,
	input wire logic        clk_ready_evt_o,
	input wire logic        wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("ack missing after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	hole_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
		&& wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	req_pulse_a: assert property (sys_rst_req_o |=> !sys_rst_req_o)
		else $error("reset request not a pulse");
	evt_pulse_a: assert property (clk_ready_evt_o |=> !clk_ready_evt_o)
		else $error("ready event not a pulse");
	wake_level_a: assert property (wake_o == (irq_o && (sleep_i || (deep_power_i && LOW_POWER))))
		else $error("wake level wrong");
	rst_quiet_a: assert property ($fell(rst_i) |-> !irq_o && !sys_rst_req_o && !wb_ack_o)
		else $error("outputs active after reset");
endmodule : wwdt_timer_checker

// [test/wwdt_timer_tb.sv]
/*
 Self-checking bench for wwdt_timer with a reference model.
 Assumes the reset partner model; late limits are too long to reach here.
*/
`timescale 1ns/1ps
`include "wwdt_defs.svh"
module wwdt_timer_tb;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep = 0, ce = 1;
	logic        ack, irq, req, evt, wake, sys_rst, rdy = 0, armed = 0;
	logic [3:0]  adr = 4'h0;
	logic [2:0]  src = 3'h0;
	logic [1:0]  csel_m = 2'h0;
	logic [31:0] wdat = 32'h0, rdat, got, ctrl_m = 32'h0;
	int          n_fail = 0, num_checks = 0, seed = 80, cyc_cnt = 0, n_evt = 0, exp_req = 0;
	int          n_req;
	longint      cnt_m = 0;
	wwdt_timer #(.LOW_POWER(1'b0)) DUT (.clk_i(clk_i), .rst_i(rst_i), .sys_rst_i(sys_rst),
		.ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tick_src_i(src),
		.sleep_i(sleep), .deep_power_i(1'b0), .irq_o(irq), .sys_rst_req_o(req),
		.clk_ready_evt_o(evt), .wake_o(wake));
	wwdt_rst_model #(.DELAY(3)) u_sys (.clk_i(clk_i), .sys_rst_req_i(req), .sys_rst_o(sys_rst),
		.n_req_o(n_req));
	initial forever #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (evt === 1'b1) n_evt++;
		if (cyc_cnt == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task fail(input string m);
		n_fail++;
		$display("unexpected %0t %s", $time, m);
	endtask : fail
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 20);
		if (ack !== 1'b1) fail("no ack");
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	function logic [31:0] ctrl_e();
		return ctrl_m | {3'h0, rdy, 28'h0};
	endfunction : ctrl_e
	task chk_rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		num_checks++;
		if (got !== e) fail("read data");
	endtask : chk_rd
	task chk_val(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) fail("output value");
	endtask : chk_val
	// Write plus reference model update
	task wr(input logic [3:0] a, input logic [31:0] d);
		longint re, ie;
		bus(1'b1, a, d);
		if (a == `WWDT_CTRL_OFS) begin
			if (d[8] != ctrl_m[8]) rdy = 1'b1;
			ctrl_m = d & 32'hE8FF_1FFF;
		end
		if (a == `WWDT_CLKSEL_OFS) csel_m = d[1:0];
		if (a == `WWDT_FEED_OFS) begin
			if (d[7:0] == `WWDT_KEY_SECOND && armed) begin
				re = 64'h1 << (31 - ctrl_m[23:20]);
				ie = 64'h1 << (31 - ctrl_m[19:16]);
				if (cnt_m < re) begin
					ctrl_m[30] = 1'b1;
					exp_req += ctrl_m[29] & ctrl_m[11];
				end else if (cnt_m < ie) ctrl_m[12] = 1'b1;
				cnt_m = 0;
			end
			armed = (d[7:0] == `WWDT_KEY_FIRST);
		end
	endtask : wr
	task feed;
		wr(`WWDT_FEED_OFS, {24'h0, `WWDT_KEY_FIRST});
		repeat ($unsigned($random(seed)) % 20) @(posedge clk_i);
		wr(`WWDT_CLKSEL_OFS, 32'($unsigned($random(seed)) % 2));
		wr(`WWDT_FEED_OFS, {24'h0, `WWDT_KEY_SECOND});
	endtask : feed
	// All sources toggle together, so the selection never starves ticks
	task tick(input int n);
		if (ctrl_m[8]) cnt_m += n;
		repeat (n) begin
			@(posedge clk_i);
			src <= 3'h7;
			repeat (2) @(posedge clk_i);
			src <= 3'h0;
			repeat (2) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask : tick
	////////////////////////////////////////////////////////////////
	initial begin
		int t;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_rd(`WWDT_CTRL_OFS, 32'h0);
		chk_rd(`WWDT_CLKSEL_OFS, 32'h0);
		chk_rd(`WWDT_COUNT_OFS, 32'h0);
		chk_rd(4'h2, 32'h0);
		feed();
		chk_rd(`WWDT_CTRL_OFS, ctrl_e());
		wr(`WWDT_CTRL_OFS, 32'h0000_0100);
		tick(3 + $unsigned($random(seed)) % 8);
		chk_rd(`WWDT_COUNT_OFS, cnt_m[31:0]);
		wr(`WWDT_CTRL_OFS, 32'h0);
		tick(5);
		chk_rd(`WWDT_COUNT_OFS, cnt_m[31:0]);
		wr(`WWDT_CTRL_OFS, 32'h0000_0100);
		tick(2);
		// Frozen core must miss these ticks, so take them back out of the model
		ce <= 1'b0;
		tick(3);
		cnt_m -= 3;
		ce <= 1'b1;
		wr(`WWDT_FEED_OFS, {24'h0, `WWDT_KEY_FIRST});
		wr(`WWDT_FEED_OFS, 32'h0000_0033);
		wr(`WWDT_FEED_OFS, {24'h0, `WWDT_KEY_SECOND});
		chk_rd(`WWDT_COUNT_OFS, cnt_m[31:0]);
		feed();
		chk_rd(`WWDT_COUNT_OFS, cnt_m[31:0]);
		chk_rd(`WWDT_CTRL_OFS, ctrl_e());
		chk_rd(`WWDT_CLKSEL_OFS, {30'h0, csel_m});
		for (int i = 0; i < 8; i++) begin
			sleep <= 1'($random(seed));
			wr(`WWDT_CTRL_OFS, 32'h500 | (i[0] << 9) | (i[1] << 12) | (i[2] << 29));
			@(posedge clk_i);
			chk_val(irq, i[0] | (i[1] & i[2]));
			chk_val(wake, (i[0] | (i[1] & i[2])) & sleep);
		end
		wr(`WWDT_CTRL_OFS, 32'h0800_0000);
		feed();
		wr(`WWDT_CTRL_OFS, 32'h0800_0100);
		repeat (3) @(posedge clk_i);
		chk_val(n_evt, 2);
		chk_rd(`WWDT_CTRL_OFS, ctrl_e());
		wr(`WWDT_CTRL_OFS, 32'h20F0_0900);
		tick(3);
		feed();
		t = 0;
		while (sys_rst !== 1'b1 && t < 50) begin
			@(posedge clk_i);
			t++;
		end
		if (sys_rst !== 1'b1) fail("no system reset");
		@(posedge clk_i);
		ctrl_m &= 32'hC000_0100;
		csel_m = 2'h0;
		cnt_m = 0;
		armed = 1'b0;
		chk_rd(`WWDT_CTRL_OFS, ctrl_e());
		chk_rd(`WWDT_COUNT_OFS, 32'h0);
		tick(4);
		chk_rd(`WWDT_COUNT_OFS, cnt_m[31:0]);
		chk_val(n_req, exp_req);
		report_and_stop();
	end
endmodule : wwdt_timer_tb
bind wwdt_timer wwdt_timer_checker #(.LOW_POWER(LOW_POWER)) u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
	.deep_power_i(deep_power_i), .irq_o(irq_o), .sys_rst_req_o(sys_rst_req_o),
	.clk_ready_evt_o(clk_ready_evt_o), .wake_o(wake_o));
